// [tb/dxz_dev_model.sv]
// Behavioural memory device: command path state around power-save mode.
// Assumes events arrive on the controller clock as the guard sees them.
module dxz_dev_model #(
    parameter int TMOD_NCK = 24,
    parameter int CPDED_NCK = 4
) (
    // Clock, reset, events
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire dxz_pkg::dxz_event_t event_i,
    // Command path state
    output logic cmd_on_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Path closes only after the update and disable delays, so late commands still land
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i || event_i == dxz_pkg::DXZ_EV_MPSM_EXIT) cmd_on_o <= 1'b1;
        else if (event_i == dxz_pkg::DXZ_EV_MPSM_ENTRY) cmd_on_o <= #((TMOD_NCK + CPDED_NCK) * 25) 1'b0;
    end
endmodule : dxz_dev_model

// [tb/dxz_guard_chk.sv]
// Concurrent checks on the spacing guard's permission outputs.
// Assumes default count parameters and one-cycle event pulses.
module dxz_guard_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Watched ports
    input wire dxz_pkg::dxz_event_t event_i,
    input wire logic sr_abort_en_i,
    input wire logic cs_exit_ready_i,
    input wire logic allow_any_o,
    input wire logic allow_nodll_o,
    input wire logic allow_fast_o,
    input wire logic clk_needed_o,
    input wire logic cke_exit_ok_o,
    input wire logic in_mpsm_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Gaps must still be closed on their last counted edge; later events may only lengthen
    zq_short_a: assert property (event_i == dxz_pkg::DXZ_EV_ZQ_SHORT |-> ##129 !allow_any_o)
        else $error("short calibration gap cut");
    zq_long_a: assert property (event_i == dxz_pkg::DXZ_EV_ZQ_LONG |-> ##300 ##213 !allow_any_o)
        else $error("long calibration gap cut");
    reset_exit_a: assert property (event_i == dxz_pkg::DXZ_EV_RESET_EXIT |-> ##2 !allow_any_o ##10 !allow_any_o)
        else $error("reset exit gap cut");
    sr_nodll_a: assert property (event_i == dxz_pkg::DXZ_EV_SR_EXIT && !sr_abort_en_i |-> ##12 !allow_nodll_o)
        else $error("self refresh exit gap cut");
    sr_fast_a: assert property (event_i == dxz_pkg::DXZ_EV_SR_EXIT |-> ##2 !allow_fast_o [*6])
        else $error("fast exit gap cut");
    clk_hold_a: assert property (event_i == dxz_pkg::DXZ_EV_MPSM_ENTRY && !in_mpsm_o |-> ##1 clk_needed_o ##28 clk_needed_o)
        else $error("clock released early");
    clk_lead_a: assert property (event_i == dxz_pkg::DXZ_EV_MPSM_CLK_ON && in_mpsm_o |=> !cke_exit_ok_o [*5])
        else $error("exit allowed before clock lead");
    cs_setup_a: assert property ($rose(cke_exit_ok_o) |-> $past(cs_exit_ready_i))
        else $error("exit allowed without chip select setup");
endmodule : dxz_guard_chk
bind dxz_guard dxz_guard_chk u_chk (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .event_i(event_i),
    .sr_abort_en_i(sr_abort_en_i),
    .cs_exit_ready_i(cs_exit_ready_i),
    .allow_any_o(allow_any_o),
    .allow_nodll_o(allow_nodll_o),
    .allow_fast_o(allow_fast_o),
    .clk_needed_o(clk_needed_o),
    .cke_exit_ok_o(cke_exit_ok_o),
    .in_mpsm_o(in_mpsm_o)
);

// [tb/dxz_guard_tb.sv]
// Self-checking bench for the spacing guard beside a device model.
// Assumes the guard's default count parameters.
`include "dxz_map.svh"
module dxz_guard_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    dxz_pkg::dxz_event_t event_i = dxz_pkg::DXZ_EV_NONE;
    logic sr_abort_en_i = 1'b0;
    logic cs_exit_ready_i = 1'b0;
    logic allow_any_o, allow_nodll_o, allow_fast_o, clk_needed_o, cke_exit_ok_o, in_mpsm_o, cmd_on_o;
    logic [11:0] t[5];
    int errors = 0;
    int compares = 0;
    // Top bit marks the clock as free, so the hold after entry is timed like a permission
    wire logic [4:0] seen_w = {!clk_needed_o, cke_exit_ok_o, allow_fast_o, allow_nodll_o, allow_any_o};
    dxz_guard DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .event_i(event_i), .sr_abort_en_i(sr_abort_en_i),
        .cs_exit_ready_i(cs_exit_ready_i), .allow_any_o(allow_any_o), .allow_nodll_o(allow_nodll_o),
        .allow_fast_o(allow_fast_o), .clk_needed_o(clk_needed_o), .cke_exit_ok_o(cke_exit_ok_o),
        .in_mpsm_o(in_mpsm_o));
    dxz_dev_model u_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .event_i(event_i), .cmd_on_o(cmd_on_o));
    // Free-running 40 MHz clock
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // Pulse one event, then note the first edge at which each permission is high within len edges
    task automatic gap(input dxz_pkg::dxz_event_t ev, input int len = 1100);
        event_i = ev;
        @(posedge mclk_i);
        #1 event_i = dxz_pkg::DXZ_EV_NONE;
        t = '{default: 12'h000};
        for (int k = 1; k < len; k++) begin
            @(posedge mclk_i);
            #1;
            foreach (t[i]) if (t[i] == 12'h000 && seen_w[i] === 1'b1) t[i] = 12'(k);
        end
    endtask : gap
    task automatic t_zq();
        gap(dxz_pkg::DXZ_EV_RESET_EXIT);
        check("reset exit", t[0], 12'h00C);
        gap(dxz_pkg::DXZ_EV_ZQ_INIT);
        check("zq init", t[0], 12'(`DXZ_ZQINIT_NCK + 1));
        gap(dxz_pkg::DXZ_EV_ZQ_LONG);
        check("zq long", t[0], 12'(`DXZ_ZQOPER_NCK + 1));
        gap(dxz_pkg::DXZ_EV_ZQ_SHORT);
        check("zq short", t[1], 12'(`DXZ_ZQCS_NCK + 1));
        $display("calibration test done");
    endtask : t_zq
    // Self refresh exit without and with abort
    task automatic t_srx();
        gap(dxz_pkg::DXZ_EV_SR_EXIT);
        check("sr nodll", t[1], 12'h00C);
        check("sr fast", t[2], 12'h008);
        sr_abort_en_i = 1'b1;
        gap(dxz_pkg::DXZ_EV_SR_EXIT);
        check("sr abort nodll", t[1], 12'h008);
        sr_abort_en_i = 1'b0;
        $display("self refresh test done");
    endtask : t_srx
    // Full power-save entry, clock restart, chip select setup and exit
    task automatic t_mpsm();
        gap(dxz_pkg::DXZ_EV_MPSM_ENTRY);
        check("in mpsm", 12'(in_mpsm_o), 12'h001);
        check("clock hold", t[4], 12'(`DXZ_TMOD_NCK + `DXZ_CPDED_NCK + 1));
        check("device path off", 12'(cmd_on_o), 12'h000);
        check("no early exit", 12'(cke_exit_ok_o), 12'h000);
        cs_exit_ready_i = 1'b1;
        gap(dxz_pkg::DXZ_EV_MPSM_CLK_ON);
        check("clock back", 12'(clk_needed_o), 12'h001);
        check("clock lead", t[3], 12'(`DXZ_MAX(`DXZ_CKSRX_NCK, `DXZ_NS_TO_CYC(`DXZ_EXTRA_NS)) + 1));
        cs_exit_ready_i = 1'b0;
        gap(dxz_pkg::DXZ_EV_NONE, 20);
        check("exit without cs", t[3], 12'h000);
        cs_exit_ready_i = 1'b1;
        gap(dxz_pkg::DXZ_EV_NONE, 20);
        check("cs setup", t[3], 12'(`DXZ_MAX(1, `DXZ_NS_TO_CYC(`DXZ_TIS_TIH_NS)) + 1));
        gap(dxz_pkg::DXZ_EV_MPSM_EXIT);
        cs_exit_ready_i = 1'b0;
        check("mpsm nodll", t[1], 12'h00C);
        check("mpsm dll", t[0], 12'(12 + `DXZ_TDLLK_NCK));
        check("mpsm left", 12'(in_mpsm_o), 12'h000);
        check("device path on", 12'(cmd_on_o), 12'h001);
        $display("power save test done");
    endtask : t_mpsm
    // Reset in the middle of power-save mode drops the mode and frees every command permission
    task automatic t_reset();
        gap(dxz_pkg::DXZ_EV_MPSM_ENTRY, 40);
        check("entry again", 12'(in_mpsm_o), 12'h001);
        nrst_i = 1'b0;
        #1;
        check("reset clock", 12'(clk_needed_o), 12'h001);
        check("reset mode", 12'(in_mpsm_o), 12'h000);
        repeat (2) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        @(posedge mclk_i);
        #1;
        check("after reset", 12'(seen_w), 12'h007);
        $display("mid-run reset test done");
    endtask : t_reset
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        @(posedge mclk_i);
        #1;
        t_zq();
        t_srx();
        t_mpsm();
        t_reset();
        close_out();
    end
    // Watchdog: nine gaps of 1100 cycles plus margin
    initial begin
        #(12000 * 25);
        errors++;
        close_out();
    end
endmodule : dxz_guard_tb

// [verilog/dxz_counter.sv]
// Down counter that holds a gap open until it reaches zero.
// Assumes load and value come from logic on the same clock.
module dxz_counter #(
    parameter int W = 12
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Load
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    // State
    output logic busy_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // A load only lengthens the wait, never shortens a running one; a held load keeps it full
    assign cnt_d = (load_i && value_i >= cnt_q) ? value_i :
                   (cnt_q != {W{1'b0}}) ? cnt_q - {{(W-1){1'b0}}, 1'b1} : cnt_q;

    // Count register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = (cnt_q != {W{1'b0}});
endmodule : dxz_counter

// [verilog/dxz_guard.sv]
// Controller-side guard that enforces command spacing after calibration,
// reset exit, self refresh exit and maximum power saving mode.
// Assumes events come as one-cycle pulses from the command scheduler on mclk_i.
//
// Behaviour
// - Init calibration blocks commands 1024 cycles
// - Long calibration blocks commands 512 cycles
// - Short calibration blocks commands 128 cycles
// - Reset exit waits max(5, refresh+10ns)
// - Self refresh exit waits refresh+10ns
// - Abort enabled exit waits 4x refresh+10ns
// - Calibration and latency mode writes wait 4x+10ns
// - Clock kept valid update+4 after entry
// - Clock valid max(5,10ns) before power-save exit
// - Non-DLL commands wait self refresh exit delay
// - DLL commands wait exit plus DLL delay
// - Chip select leads clock enable by setup+hold
// - Clock-valid time is max(5 cycles, 10ns)
`include "dxz_map.svh"
module dxz_guard #(
    parameter int CNT_W = 12,
    parameter int TRFC_NS = `DXZ_TRFC_NS,
    parameter int TRFC4_NS = `DXZ_TRFC4_NS,
    parameter int TMOD_NCK = `DXZ_TMOD_NCK,
    parameter int TDLLK_NCK = `DXZ_TDLLK_NCK
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Event pulses from the scheduler
    input wire dxz_pkg::dxz_event_t event_i,
    input wire logic sr_abort_en_i,
    // Chip select level currently requested for power-save exit
    input wire logic cs_exit_ready_i,
    // Permissions
    output logic allow_any_o,
    output logic allow_nodll_o,
    output logic allow_fast_o,
    output logic clk_needed_o,
    output logic cke_exit_ok_o,
    output logic in_mpsm_o
);
    // Cycle counts derived from times, rounded up
    localparam int XPR_CYC = `DXZ_MAX(`DXZ_CKSRX_NCK, `DXZ_NS_TO_CYC(TRFC_NS + `DXZ_EXTRA_NS));
    localparam int XS_CYC = `DXZ_NS_TO_CYC(TRFC_NS + `DXZ_EXTRA_NS);
    localparam int XS4_CYC = `DXZ_NS_TO_CYC(TRFC4_NS + `DXZ_EXTRA_NS);
    localparam int CKSRX_CYC = `DXZ_MAX(`DXZ_CKSRX_NCK, `DXZ_NS_TO_CYC(`DXZ_EXTRA_NS));
    localparam int MPE_CYC = TMOD_NCK + `DXZ_CPDED_NCK;
    localparam int MPX_S_CYC = `DXZ_MAX(1, `DXZ_NS_TO_CYC(`DXZ_TIS_TIH_NS));

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = n[CNT_W-1:0];
    endfunction : cyc

    dxz_pkg::dxz_state_t st_q;
    dxz_pkg::dxz_state_t st_d;
    logic any_busy;
    logic nodll_busy;
    logic fast_busy;
    logic clk_busy;
    logic cs_busy;
    logic [CNT_W-1:0] any_val;
    logic [CNT_W-1:0] nodll_val;
    logic [CNT_W-1:0] fast_val;
    logic any_ld;
    logic nodll_ld;
    logic fast_ld;
    logic clk_ld;
    logic [CNT_W-1:0] clk_val;
    logic cs_ld;
    logic cs_q;
    logic allow_any_q;
    logic allow_nodll_q;
    logic allow_fast_q;
    logic clk_needed_q;
    logic cke_exit_ok_q;
    logic in_mpsm_q;
    logic allow_any_d;
    logic allow_nodll_d;
    logic allow_fast_d;
    logic clk_needed_d;
    logic cke_exit_ok_d;
    logic in_mpsm_d;

    // Event decode into counter loads
    wire ev_rst = (event_i == dxz_pkg::DXZ_EV_RESET_EXIT);
    wire ev_zqi = (event_i == dxz_pkg::DXZ_EV_ZQ_INIT);
    wire ev_zql = (event_i == dxz_pkg::DXZ_EV_ZQ_LONG);
    wire ev_zqs = (event_i == dxz_pkg::DXZ_EV_ZQ_SHORT);
    wire ev_srx = (event_i == dxz_pkg::DXZ_EV_SR_EXIT);
    wire ev_mpe = (event_i == dxz_pkg::DXZ_EV_MPSM_ENTRY) && (st_q == dxz_pkg::DXZ_ST_RUN);
    wire ev_mpc = (event_i == dxz_pkg::DXZ_EV_MPSM_CLK_ON) && (st_q == dxz_pkg::DXZ_ST_MPSM);
    wire ev_mpx = (event_i == dxz_pkg::DXZ_EV_MPSM_EXIT) && (st_q == dxz_pkg::DXZ_ST_MPSM_CLK)
                  && !clk_busy && !cs_busy && cs_q;

    // Full blocking gap: every command held back
    assign any_ld = ev_rst | ev_zqi | ev_zql | ev_zqs | ev_mpx | ev_srx;
    assign any_val = ev_zqi ? cyc(`DXZ_ZQINIT_NCK) :
                     ev_zql ? cyc(`DXZ_ZQOPER_NCK) :
                     ev_zqs ? cyc(`DXZ_ZQCS_NCK) :
                     ev_rst ? cyc(XPR_CYC) :
                     ev_mpx ? cyc(XS_CYC + TDLLK_NCK) :
                     cyc(XS_CYC + TDLLK_NCK);
    // Gap for commands not needing a locked DLL
    assign nodll_ld = ev_srx | ev_mpx | any_ld;
    assign nodll_val = ev_srx ? (sr_abort_en_i ? cyc(XS4_CYC) : cyc(XS_CYC)) :
                       ev_mpx ? cyc(XS_CYC) :
                       any_val;
    // Gap for calibration and latency mode writes after self refresh exit
    assign fast_ld = ev_srx | (any_ld & ~ev_srx);
    assign fast_val = ev_srx ? cyc(XS4_CYC) : nodll_val;
    // Clock hold after entry, clock lead before exit
    assign clk_ld = ev_mpe | ev_mpc;
    assign clk_val = ev_mpe ? cyc(MPE_CYC) : cyc(CKSRX_CYC);
    assign cs_ld = ev_mpc | (st_q == dxz_pkg::DXZ_ST_MPSM_CLK && !cs_q);

    // One counter per gap, the clock hold and clock lead sharing u_clk; each runs on its own so a long gap never hides a short one
    dxz_counter #(
        .W(CNT_W)
    ) u_any (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .load_i(any_ld),
        .value_i(any_val),
        .busy_o(any_busy)
    );

    // Gap for commands that do not need a locked DLL
    dxz_counter #(
        .W(CNT_W)
    ) u_nodll (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .load_i(nodll_ld),
        .value_i(nodll_val),
        .busy_o(nodll_busy)
    );

    // Gap for calibration and latency mode writes
    dxz_counter #(
        .W(CNT_W)
    ) u_fast (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .load_i(fast_ld),
        .value_i(fast_val),
        .busy_o(fast_busy)
    );

    // Clock hold after entry and clock lead before exit share one counter
    dxz_counter #(
        .W(CNT_W)
    ) u_clk (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .load_i(clk_ld),
        .value_i(clk_val),
        .busy_o(clk_busy)
    );

    // Chip select setup; reloaded every cycle while chip select is not yet at its exit level
    dxz_counter #(
        .W(CNT_W)
    ) u_cs (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .load_i(cs_ld),
        .value_i(cyc(MPX_S_CYC)),
        .busy_o(cs_busy)
    );

    // Power-save mode sequencing; the guard clears allow_any_o, allow_nodll_o and allow_fast_o whenever st_d leaves DXZ_ST_RUN
    always_comb begin
        st_d = st_q;
        case (st_q)
            dxz_pkg::DXZ_ST_RUN: if (ev_mpe) st_d = dxz_pkg::DXZ_ST_MPSM;
            dxz_pkg::DXZ_ST_MPSM: if (ev_mpc) st_d = dxz_pkg::DXZ_ST_MPSM_CLK;
            dxz_pkg::DXZ_ST_MPSM_CLK: if (ev_mpx) st_d = dxz_pkg::DXZ_ST_RUN;
            default: st_d = dxz_pkg::DXZ_ST_RUN;
        endcase
    end

    // Next permissions; a load in this cycle counts as busy, since the counter shows it one edge later
    assign allow_any_d = !any_busy && !any_ld && (st_d == dxz_pkg::DXZ_ST_RUN);
    assign allow_nodll_d = !nodll_busy && !nodll_ld && (st_d == dxz_pkg::DXZ_ST_RUN);
    assign allow_fast_d = !fast_busy && !fast_ld && (st_d == dxz_pkg::DXZ_ST_RUN);
    // Clock may stop only in power-save mode, once the entry hold has run out
    assign clk_needed_d = (st_d != dxz_pkg::DXZ_ST_MPSM) || clk_busy || clk_ld;
    // Exit needs both the clock lead and the chip select setup to have run out
    assign cke_exit_ok_d = (st_d == dxz_pkg::DXZ_ST_MPSM_CLK) && !clk_busy && !clk_ld
                           && !cs_busy && !cs_ld && cs_q;
    assign in_mpsm_d = (st_d != dxz_pkg::DXZ_ST_RUN);

    // State and registered permissions
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= dxz_pkg::DXZ_ST_RUN;
            cs_q <= 1'b0;
            allow_any_q <= 1'b0;
            allow_nodll_q <= 1'b0;
            allow_fast_q <= 1'b0;
            clk_needed_q <= 1'b1;
            cke_exit_ok_q <= 1'b0;
            in_mpsm_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cs_q <= cs_exit_ready_i;
            allow_any_q <= allow_any_d;
            allow_nodll_q <= allow_nodll_d;
            allow_fast_q <= allow_fast_d;
            clk_needed_q <= clk_needed_d;
            cke_exit_ok_q <= cke_exit_ok_d;
            in_mpsm_q <= in_mpsm_d;
        end
    end

    // Ports come straight from the permission flops, so the scheduler sees no glitches
    assign allow_any_o = allow_any_q;
    assign allow_nodll_o = allow_nodll_q;
    assign allow_fast_o = allow_fast_q;
    assign clk_needed_o = clk_needed_q;
    assign cke_exit_ok_o = cke_exit_ok_q;
    assign in_mpsm_o = in_mpsm_q;
endmodule : dxz_guard

// [verilog/dxz_map.svh]
// Timing constants for the exit and calibration spacing guard.
// Assumes a 40 MHz controller clock equal to the memory command clock rate.
`ifndef DXZ_MAP_SVH
`define DXZ_MAP_SVH
`define DXZ_CLK_PS 25000
`define DXZ_ZQINIT_NCK 1024
`define DXZ_ZQOPER_NCK 512
`define DXZ_ZQCS_NCK 128
`define DXZ_EXTRA_NS 10
`define DXZ_CKSRX_NCK 5
`define DXZ_CPDED_NCK 4
`define DXZ_TRFC_NS 260
`define DXZ_TRFC4_NS 160
`define DXZ_TMOD_NCK 24
`define DXZ_TDLLK_NCK 597
`define DXZ_TIS_TIH_NS 1
`define DXZ_NS_TO_CYC(ns) ((((ns) * 1000) + `DXZ_CLK_PS - 1) / `DXZ_CLK_PS)
`define DXZ_MAX(a, b) (((a) > (b)) ? (a) : (b))
`endif

// [verilog/dxz_pkg.sv]
// Types shared by the exit and calibration spacing guard.
// Assumes nothing of its surroundings.
package dxz_pkg;
    typedef enum logic [3:0] {
        DXZ_EV_NONE = 4'h0,
        DXZ_EV_RESET_EXIT = 4'h1,
        DXZ_EV_ZQ_INIT = 4'h2,
        DXZ_EV_ZQ_LONG = 4'h3,
        DXZ_EV_ZQ_SHORT = 4'h4,
        DXZ_EV_SR_EXIT = 4'h5,
        DXZ_EV_MPSM_ENTRY = 4'h6,
        DXZ_EV_MPSM_CLK_ON = 4'h7,
        DXZ_EV_MPSM_EXIT = 4'h8
    } dxz_event_t;
    typedef enum logic [1:0] {
        DXZ_ST_RUN = 2'h0,
        DXZ_ST_MPSM = 2'h1,
        DXZ_ST_MPSM_CLK = 2'h2
    } dxz_state_t;
endpackage : dxz_pkg
